// ### pkg/dfr_map.vh
`ifndef DFR_MAP_VH
`define DFR_MAP_VH
// Functional notes
// - Input codes 5 to 8 pick speed bits
// - Input code 9 is the jog select
// - Speed bits index preset table, bit 1 low
// - Jog select overrides the speed bits
// - Clamp below upper limit percent of maximum
// - Clamp above lower limit percent of maximum
// - New upper limit trims preset entries above it
// - Inside skip band, hold target at upper edge
// - Skip centre of zero disables that band
// - Output ramps across bands, never settles within
// - Hold mode acts only with Up/Down assigned
// - Mode 0: adjust when running, clear at stop
// - Mode 1: save at stop, resume, early clear
// - Mode 2: adjust when stopped, save at stop
// - Up2/Down2 add or subtract a bias
// - Zero bias step: Up2/Down2 ramp the bias
// - Nonzero step: short press steps, long ramps
// - Ramp select 0 uses active accel/decel
// - Alarm when both Up/Down kinds assigned

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DFR_O_PRESET  8'h00
`define DFR_O_JOG     8'h40
`define DFR_O_UPPCT   8'h44
`define DFR_O_LOPCT   8'h48
`define DFR_O_MAXF    8'h4C
`define DFR_O_SKIP1   8'h50
`define DFR_O_SKIP2   8'h54
`define DFR_O_SKIPW   8'h58
`define DFR_O_MODE    8'h5C
`define DFR_O_STEP    8'h60
`define DFR_O_RSEL    8'h64
`define DFR_O_SAVED   8'h68
`define DFR_O_IFS     8'h6C
`define DFR_O_ACCEL   8'h70
`define DFR_O_DECEL   8'h74
`define DFR_O_STATUS  8'h78
`define DFR_O_REF     8'h7C

// ----------------------------------------------------------------
// Fields, codes and modes
// ----------------------------------------------------------------
`define DFR_FN_MS1    4'h5
`define DFR_FN_MS4    4'h8
`define DFR_FN_JOG    4'h9
`define DFR_FN_UP     4'hA
`define DFR_FN_DN     4'hB
`define DFR_FN_UP2    4'hC
`define DFR_FN_DN2    4'hD
`define DFR_MODE_CLR  2'h0
`define DFR_MODE_SAVE 2'h1
`define DFR_MODE_ACPT 2'h2
`define DFR_STS_ALM   16
`define DFR_STS_RUN   17
`define DFR_PCT_DIV   27'h3E8
`define DFR_BIAS_MAX  18'sh0270F

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DFR_R_PRE0    16'h01F4
`define DFR_R_PRE1    16'h0320
`define DFR_R_PRE2    16'h03E8
`define DFR_R_PRE3    16'h04B0
`define DFR_R_PRE4    16'h05DC
`define DFR_R_PRE5    16'h07D0
`define DFR_R_PRE6    16'h09C4
`define DFR_R_PRE7    16'h0BB8
`define DFR_R_PRE8    16'h0DAC
`define DFR_R_PRE9    16'h0FA0
`define DFR_R_PRE10   16'h1068
`define DFR_R_PRE11   16'h1194
`define DFR_R_PRE12   16'h1388
`define DFR_R_PRE13   16'h1388
`define DFR_R_PRE14   16'h1388
`define DFR_R_PRE15   16'h1388
`define DFR_R_JOG     16'h0258
`define DFR_R_UPPCT   11'h3E8
`define DFR_R_LOPCT   11'h000
`define DFR_R_MAXF    16'h1770
`define DFR_R_SKIP    16'h0000
`define DFR_R_SKIPW   16'h0064
`define DFR_R_RAMP    24'h07A120

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DFR_CLK_HZ    50000000
`define DFR_HOLD_S    2
`endif

// ### core/dfr_top.v
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`include "dfr_map.vh"

// ----------------------------------------------------------------
// Step divider: one pulse every period cycles while enabled
// ----------------------------------------------------------------
module dfr_tick #(
	parameter W = 24
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire         en,
	input  wire [W-1:0] period,
	output reg          tick_q
);

reg [W-1:0] cnt_q;

always @(posedge clk) begin
	if (!rst_b || !en) begin
		cnt_q  <= {W{1'h0}};
		tick_q <= 1'h0;
	end else if (cnt_q == {W{1'h0}}) begin
		tick_q <= 1'h1;
		cnt_q  <= (period == {W{1'h0}}) ? {W{1'h0}} : period - 1'h1;
	end else begin
		tick_q <= 1'h0;
		cnt_q  <= cnt_q - 1'h1;
	end
end

endmodule

// ----------------------------------------------------------------
// Frequency reference selector
// ----------------------------------------------------------------
module dfr_top #(
	parameter [31:0] HOLD_CYC = `DFR_CLK_HZ * `DFR_HOLD_S,
	parameter        RW       = 24
) (
	input  wire        REF_CLK,
	input  wire        RST_B,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [7:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output wire [31:0] WB_DAT_O,
	output wire        WB_ACK_O,
	input  wire [7:0]  MF_IN,
	input  wire        RUN_IN,
	input  wire        PWR_FAIL_IN,
	output wire [15:0] FREQ_TARGET,
	output wire [15:0] FREQ_OUT,
	output wire        UD_ALARM
);

localparam [255:0] PRE_RST = {`DFR_R_PRE15, `DFR_R_PRE14, `DFR_R_PRE13,
	`DFR_R_PRE12, `DFR_R_PRE11, `DFR_R_PRE10, `DFR_R_PRE9, `DFR_R_PRE8,
	`DFR_R_PRE7, `DFR_R_PRE6, `DFR_R_PRE5, `DFR_R_PRE4, `DFR_R_PRE3,
	`DFR_R_PRE2, `DFR_R_PRE1, `DFR_R_PRE0};

reg  [15:0]   pre_q [0:15];
reg  [15:0]   jog_q;
reg  [10:0]   up_pct_q;
reg  [10:0]   lo_pct_q;
reg  [15:0]   max_q;
reg  [15:0]   sk1_q;
reg  [15:0]   sk2_q;
reg  [15:0]   skw_q;
reg  [1:0]    mode_q;
reg  [15:0]   step_q;
reg           rsel_q;
reg  [15:0]   saved_q;
reg  [31:0]   ifs_q;
reg  [RW-1:0] acc_q;
reg  [RW-1:0] dec_q;
reg           ack_q;
reg  [31:0]   dat_q;
reg           clip_q;
reg  [31:0]   rd;
reg  [9:0]    s1_q;
reg  [9:0]    s2_q;
reg  [9:0]    s3_q;
reg  [9:0]    pin_q;
reg           run_p_q;
reg           pwr_p_q;
reg           kp_q;
reg  [3:0]    ms;
reg           jog;
reg           up1;
reg           dn1;
reg           up2;
reg           dn2;
reg           a1;
reg           a2;
reg  [3:0]    fc;
reg  [15:0]   ud_q;
reg  [15:0]   bias_q;
reg  [31:0]   p_cnt_q;
reg           prs_q;
reg           dir_q;
reg  [15:0]   tgt_q;
reg  [15:0]   out_q;
reg           alm_q;
integer       i;
integer       j;

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function [31:0] mrg;
	input [31:0] o;
	input [31:0] d;
	input [3:0]  s;
	integer b;
	begin
		for (b = 0; b < 4; b = b + 1)
			mrg[8*b +: 8] = s[b] ? d[8*b +: 8] : o[8*b +: 8];
	end
endfunction

function [15:0] pct;
	input [15:0] m;
	input [10:0] p;
	reg   [26:0] q;
	begin
		q   = ({11'h0, m} * {16'h0, p}) / `DFR_PCT_DIV;
		pct = (q[26:16] != 11'h0) ? 16'hFFFF : q[15:0];
	end
endfunction

// Band edges in 17 bits so a centre near the top cannot wrap
function [15:0] skp;
	input [15:0] f;
	input [15:0] c;
	input [15:0] h;
	reg   [16:0] top;
	begin
		top = {1'h0, c} + {1'h0, h};
		skp = f;
		if (c != 16'h0 && {1'h0, f} + {1'h0, h} >= {1'h0, c} &&
		    {1'h0, f} <= top)
			skp = top[16] ? 16'hFFFF : top[15:0];
	end
endfunction

// ----------------------------------------------------------------
// Pin synchronisers: a change counts once stages 2 and 3 agree
// ----------------------------------------------------------------
wire [9:0] pins  = {PWR_FAIL_IN, RUN_IN, MF_IN};
wire [9:0] unst  = s2_q ^ s3_q;
wire       run   = pin_q[8];
wire       pwr   = pin_q[9];
wire       stp   = run_p_q & ~run;
wire       str   = ~run_p_q & run;
wire       pwr_e = pwr & ~pwr_p_q;

always @(posedge REF_CLK) begin
	if (!RST_B) begin
		s1_q    <= 10'h000;
		s2_q    <= 10'h000;
		s3_q    <= 10'h000;
		pin_q   <= 10'h000;
		run_p_q <= 1'h0;
		pwr_p_q <= 1'h0;
	end else begin
		s1_q    <= pins;
		s2_q    <= s1_q;
		s3_q    <= s2_q;
		pin_q   <= (pin_q & unst) | (s3_q & ~unst);
		run_p_q <= run;
		pwr_p_q <= pwr;
	end
end

// ----------------------------------------------------------------
// Input function decode
// ----------------------------------------------------------------
always @* begin
	ms  = 4'h0;
	jog = 1'h0;
	up1 = 1'h0;
	dn1 = 1'h0;
	up2 = 1'h0;
	dn2 = 1'h0;
	a1  = 1'h0;
	a2  = 1'h0;
	fc  = 4'h0;
	for (i = 0; i < 8; i = i + 1) begin
		fc = ifs_q[4*i +: 4];
		if (fc == `DFR_FN_UP || fc == `DFR_FN_DN)
			a1 = 1'h1;
		if (fc == `DFR_FN_UP2 || fc == `DFR_FN_DN2)
			a2 = 1'h1;
		if (pin_q[i]) begin
			if (fc >= `DFR_FN_MS1 && fc <= `DFR_FN_MS4)
				ms = ms | (4'h1 << (fc - `DFR_FN_MS1));
			if (fc == `DFR_FN_JOG)
				jog = 1'h1;
			if (fc == `DFR_FN_UP)
				up1 = 1'h1;
			if (fc == `DFR_FN_DN)
				dn1 = 1'h1;
			if (fc == `DFR_FN_UP2)
				up2 = 1'h1;
			if (fc == `DFR_FN_DN2)
				dn2 = 1'h1;
		end
	end
end

// ----------------------------------------------------------------
// Reference path
// ----------------------------------------------------------------
// Both kinds assigned is a setup fault; neither kind then acts
wire        alm = a1 & a2;
wire        u1  = a1 & ~alm;
wire        u2  = a2 & ~alm;
wire        uda = u1 | u2;
wire        aok = (mode_q == `DFR_MODE_ACPT) | run;
wire [15:0] bse = jog ? jog_q : (u1 ? ud_q : pre_q[ms]);
wire [17:0] bsx = u2 ? {{2{bias_q[15]}}, bias_q} : 18'h0;
wire [17:0] sum = {2'h0, bse} + bsx;
wire [15:0] r0  = sum[17] ? 16'h0 : (sum[16] ? 16'hFFFF : sum[15:0]);
wire [15:0] hi  = pct(max_q, up_pct_q);
wire [15:0] lo  = pct(max_q, lo_pct_q);
wire [15:0] r1  = (r0 > hi) ? hi : r0;
wire [15:0] r2  = (r1 < lo) ? lo : r1;
wire [15:0] hw  = {1'h0, skw_q[15:1]};
wire [15:0] r3  = skp(skp(r2, sk1_q, hw), sk2_q, hw);

// ----------------------------------------------------------------
// Up/Down and bias control
// ----------------------------------------------------------------
wire        k1   = u1 & (up1 ^ dn1);
wire        k2   = u2 & (up2 ^ dn2);
wire        kany = (u1 & (up1 | dn1)) | (u2 & (up2 | dn2));
wire        lng  = p_cnt_q >= HOLD_CYC - 32'h1;
wire        ramp = aok & (k1 | (k2 & (step_q == 16'h0 | lng)));
wire        dup  = k1 ? up1 : up2;
// Select value 1 is reserved and behaves as 0
wire [RW-1:0] udp = dup ? acc_q : dec_q;
wire        srel = prs_q & ~k2 & ~lng & (step_q != 16'h0) & aok;
wire        t_ud;
wire        sgn  = srel ? dir_q : dup;
wire [15:0] amt  = srel ? step_q : 16'h1;
wire signed [17:0] bs = {{2{bias_q[15]}}, bias_q};
wire signed [17:0] bn = sgn ? bs + {2'h0, amt} : bs - {2'h0, amt};
wire signed [17:0] bc = (bn > `DFR_BIAS_MAX) ? `DFR_BIAS_MAX :
	((bn < -`DFR_BIAS_MAX) ? -`DFR_BIAS_MAX : bn);
wire [15:0] udn  = up1 ? ((ud_q == 16'hFFFF) ? ud_q : ud_q + 16'h1) :
	((ud_q == 16'h0) ? ud_q : ud_q - 16'h1);

dfr_tick #(
	.W      (RW)
) u_ud_tick (
	.clk    (REF_CLK),
	.rst_b  (RST_B),
	.en     (ramp),
	.period (udp),
	.tick_q (t_ud)
);

always @(posedge REF_CLK) begin
	if (!RST_B) begin
		ud_q    <= 16'h0;
		bias_q  <= 16'h0;
		p_cnt_q <= 32'h0;
		prs_q   <= 1'h0;
		dir_q   <= 1'h0;
	end else begin
		prs_q <= k2;
		if (k2)
			dir_q <= up2;
		if (!k2)
			p_cnt_q <= 32'h0;
		else if (!lng)
			p_cnt_q <= p_cnt_q + 32'h1;
		if (uda && mode_q == `DFR_MODE_CLR && (stp || pwr_e)) begin
			ud_q   <= 16'h0;
			bias_q <= 16'h0;
		end else if (uda && mode_q == `DFR_MODE_SAVE && str) begin
			if (u1)
				ud_q <= saved_q;
			else
				bias_q <= saved_q;
		end else if (t_ud && ramp) begin
			if (k1)
				ud_q <= udn;
			else
				bias_q <= bc[15:0];
		end else if (srel) begin
			bias_q <= bc[15:0];
		end
	end
end

// ----------------------------------------------------------------
// Target and output ramp
// ----------------------------------------------------------------
// The target never sits inside a band; the ramp only passes through
wire t_out;

dfr_tick #(
	.W      (RW)
) u_out_tick (
	.clk    (REF_CLK),
	.rst_b  (RST_B),
	.en     (out_q != tgt_q),
	.period ((out_q < tgt_q) ? acc_q : dec_q),
	.tick_q (t_out)
);

always @(posedge REF_CLK) begin
	if (!RST_B) begin
		tgt_q <= 16'h0;
		out_q <= 16'h0;
		alm_q <= 1'h0;
	end else begin
		tgt_q <= run ? r3 : 16'h0;
		alm_q <= alm;
		if (t_out && out_q < tgt_q)
			out_q <= out_q + 16'h1;
		else if (t_out && out_q > tgt_q)
			out_q <= out_q - 16'h1;
	end
end

// ----------------------------------------------------------------
// Wishbone register file
// ----------------------------------------------------------------
wire [7:0]  adr = {WB_ADR_I[7:2], 2'h0};
wire        req = WB_CYC_I & WB_STB_I & ~ack_q;
wire        wr  = req & WB_WE_I;
wire [31:0] wd  = mrg(rd, WB_DAT_I, WB_SEL_I);

always @* begin
	rd = 32'h0;
	if (adr < `DFR_O_JOG)
		rd[15:0] = pre_q[adr[5:2]];
	else begin
		case (adr)
		`DFR_O_JOG:    rd[15:0] = jog_q;
		`DFR_O_UPPCT:  rd[10:0] = up_pct_q;
		`DFR_O_LOPCT:  rd[10:0] = lo_pct_q;
		`DFR_O_MAXF:   rd[15:0] = max_q;
		`DFR_O_SKIP1:  rd[15:0] = sk1_q;
		`DFR_O_SKIP2:  rd[15:0] = sk2_q;
		`DFR_O_SKIPW:  rd[15:0] = skw_q;
		`DFR_O_MODE:   rd[1:0]  = mode_q;
		`DFR_O_STEP:   rd[15:0] = step_q;
		`DFR_O_RSEL:   rd[0]    = rsel_q;
		`DFR_O_SAVED:  rd[15:0] = saved_q;
		`DFR_O_IFS:    rd       = ifs_q;
		`DFR_O_ACCEL:  rd[RW-1:0] = acc_q;
		`DFR_O_DECEL:  rd[RW-1:0] = dec_q;
		`DFR_O_STATUS: begin
			rd[15:0]         = out_q;
			rd[`DFR_STS_ALM] = alm_q;
			rd[`DFR_STS_RUN] = run;
		end
		`DFR_O_REF:    rd = {bias_q, r2};
		default:       rd = 32'h0;
		endcase
	end
end

always @(posedge REF_CLK) begin
	if (!RST_B) begin
		for (j = 0; j < 16; j = j + 1)
			pre_q[j] <= PRE_RST[16*j +: 16];
		jog_q    <= `DFR_R_JOG;
		up_pct_q <= `DFR_R_UPPCT;
		lo_pct_q <= `DFR_R_LOPCT;
		max_q    <= `DFR_R_MAXF;
		sk1_q    <= `DFR_R_SKIP;
		sk2_q    <= `DFR_R_SKIP;
		skw_q    <= `DFR_R_SKIPW;
		mode_q   <= `DFR_MODE_CLR;
		step_q   <= 16'h0;
		rsel_q   <= 1'h0;
		saved_q  <= 16'h0;
		ifs_q    <= 32'h0;
		acc_q    <= `DFR_R_RAMP;
		dec_q    <= `DFR_R_RAMP;
		ack_q    <= 1'h0;
		dat_q    <= 32'h0;
		clip_q   <= 1'h0;
		kp_q     <= 1'h0;
	end else begin
		ack_q  <= req;
		kp_q   <= kany;
		clip_q <= wr && adr == `DFR_O_UPPCT;
		if (req)
			dat_q <= rd;
		// Trim runs the cycle after the new limit lands in its register
		if (clip_q) begin
			for (j = 0; j < 16; j = j + 1)
				if (pre_q[j] > hi)
					pre_q[j] <= hi;
		end
		if (uda && mode_q != `DFR_MODE_CLR && stp)
			saved_q <= u1 ? ud_q : bias_q;
		else if (uda && mode_q == `DFR_MODE_SAVE && !run && kany && !kp_q)
			saved_q <= 16'h0;
		if (wr && adr < `DFR_O_JOG)
			pre_q[adr[5:2]] <= wd[15:0];
		else if (wr) begin
			case (adr)
			`DFR_O_JOG:   jog_q    <= wd[15:0];
			`DFR_O_UPPCT: up_pct_q <= wd[10:0];
			`DFR_O_LOPCT: lo_pct_q <= wd[10:0];
			`DFR_O_MAXF:  max_q    <= wd[15:0];
			`DFR_O_SKIP1: sk1_q    <= wd[15:0];
			`DFR_O_SKIP2: sk2_q    <= wd[15:0];
			`DFR_O_SKIPW: skw_q    <= wd[15:0];
			`DFR_O_MODE:  mode_q   <= wd[1:0];
			`DFR_O_STEP:  step_q   <= wd[15:0];
			`DFR_O_RSEL:  rsel_q   <= wd[0];
			`DFR_O_SAVED: saved_q  <= wd[15:0];
			`DFR_O_IFS:   ifs_q    <= wd;
			`DFR_O_ACCEL: acc_q    <= wd[RW-1:0];
			`DFR_O_DECEL: dec_q    <= wd[RW-1:0];
			default:      ;
			endcase
		end
	end
end

assign WB_ACK_O    = ack_q;
assign WB_DAT_O    = dat_q;
assign FREQ_TARGET = tgt_q;
assign FREQ_OUT    = out_q;
assign UD_ALARM    = alm_q;

endmodule

// ### sim/dfr_top_checker.sv
module dfr_top_checker (
	input wire logic        REF_CLK,
	input wire logic        RST_B,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_ACK_O,
	input wire logic [31:0] WB_DAT_O,
	input wire logic        RUN_IN,
	input wire logic [15:0] FREQ_TARGET,
	input wire logic [15:0] FREQ_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Bus and ramp checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RST_B);
	sequence req_s;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence halt_s;
		(FREQ_TARGET == 16'h0000) [*3];
	endsequence
	sequence stop_s;
		(!RUN_IN) [*7];
	endsequence
	ack_timing_a: assert property (req_s |=> WB_ACK_O)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
		else $error("ack without request");
	data_hold_a: assert property (!(WB_CYC_I && WB_STB_I && !WB_ACK_O)
		|=> $stable(WB_DAT_O)) else $error("read data moved while idle");
	out_step_a: assert property (FREQ_OUT != $past(FREQ_OUT) |->
		FREQ_OUT == $past(FREQ_OUT) + 16'h0001 ||
		FREQ_OUT == $past(FREQ_OUT) - 16'h0001) else $error("output jumped");
	out_bound_a: assert property (FREQ_OUT > $past(FREQ_OUT) |->
		FREQ_OUT <= $past(FREQ_TARGET) || FREQ_OUT <= $past(FREQ_TARGET, 2))
		else $error("output overshot target");
	out_settle_a: assert property ((FREQ_OUT == FREQ_TARGET)
		|=> $stable(FREQ_OUT)) else $error("output left settled target");
	stop_target_a: assert property (stop_s |-> FREQ_TARGET == 16'h0000)
		else $error("target not zero while stopped");
	stop_decel_a: assert property (halt_s |=>
		FREQ_OUT <= $past(FREQ_OUT))
		else $error("output rose while target zero");
endmodule

bind dfr_top dfr_top_checker chk (
	.REF_CLK(REF_CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O),
	.RUN_IN(RUN_IN), .FREQ_TARGET(FREQ_TARGET), .FREQ_OUT(FREQ_OUT)
);

// ### sim/dfr_pin_model.sv
module dfr_pin_model (
	output logic [7:0] mf,
	output logic       run,
	output logic       pwr
);
	timeunit 1ns;
	timeprecision 1ns;
	// Switch levels only change right after a clock edge, no bounce
	initial begin
		mf = 8'h00;
		run = 1'b0;
		pwr = 1'b0;
	end
	task set_pins(input logic [7:0] m, input logic r);
		mf <= m;
		run <= r;
	endtask
	task set_pwr(input logic p);
		pwr <= p;
	endtask
endmodule

// ### sim/tb_drive_frequency_reference_select.sv
`include "dfr_map.vh"
`define DFR_CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
	miscompares++; $display("Error at %0t: got %h want %h", $time, g, e); \
	end end
module tb_drive_frequency_reference_select;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rst_b, cyc, stb, we, ack, chk_t, run, pwr, alm;
	logic [7:0]  adr, mf;
	logic [3:0]  sel;
	logic [31:0] dat, dat_o;
	logic [15:0] tgt_o;
	int          miscompares, checks_done;
	logic [31:0] exp_q[$];
	logic [31:0] exp_v;
	int          pre[16] = '{500, 800, 1000, 1200, 1500, 2000, 2500, 3000,
		3500, 4000, 4200, 4500, 5000, 5000, 5000, 5000};
	int          i, idx;
	dfr_top #(.HOLD_CYC(32'd50)) dut (
		.REF_CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
		.WB_DAT_O(dat_o), .WB_ACK_O(ack), .MF_IN(mf), .RUN_IN(run),
		.PWR_FAIL_IN(pwr), .FREQ_TARGET(tgt_o), .FREQ_OUT(), .UD_ALARM(alm)
	);
	dfr_pin_model pins (.mf(mf), .run(run), .pwr(pwr));
	// ----------------------------------------------------------------
	// Clock, watcher, timeout
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		// Pop once: the compare macro names its expected value twice
		if (chk_t === 1'b1) begin
			exp_v = exp_q.pop_front();
			`DFR_CHK({15'h0000, alm, tgt_o}, exp_v)
		end else if (ack === 1'b1 && we === 1'b0) begin
			exp_v = exp_q.pop_front();
			`DFR_CHK(dat_o, exp_v)
		end
	end
	// A hang counts as a mismatch rather than stalling the run
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	task print_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Held until ack is sampled, then released for one idle cycle
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hF;
		adr <= a;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(1'b0, a, 32'h0000_0000);
	endtask
	task tgt(input logic [7:0] m, input logic r, input int e);
		pins.set_pins(m, r);
		exp_q.push_back(e);
		repeat (8) @(posedge clk);
		chk_t <= 1'b1;
		@(posedge clk);
		chk_t <= 1'b0;
	endtask
	initial begin
		{rst_b, cyc, stb, we, chk_t, adr, dat} = '0;
		sel = 4'hF;
		void'($urandom(77541));
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		rd(`DFR_O_JOG, 32'h0000_0258);
		rd(`DFR_O_UPPCT, 32'h0000_03E8);
		rd(`DFR_O_LOPCT, 32'h0000_0000);
		rd(`DFR_O_SKIPW, 32'h0000_0064);
		wb(1'b1, 8'h80, 32'hFFFF_FFFF);
		rd(8'h80, 32'h0000_0000);
		$display("test regs done");
		wb(1'b1, `DFR_O_ACCEL, 32'h0);
		wb(1'b1, `DFR_O_DECEL, 32'h0);
		wb(1'b1, `DFR_O_IFS, 32'h0009_8765);
		for (i = 0; i < 10; i++) begin
			idx = (i == 0) ? 0 : (i == 1) ? 15 : $urandom % 16;
			tgt(8'(idx), 1'b1, pre[idx]);
		end
		tgt({4'h1, 4'($urandom)}, 1'b1, 600);
		$display("test select done");
		wb(1'b1, `DFR_O_UPPCT, 32'd500);
		tgt(8'd12, 1'b1, 3000);
		rd(8'h30, 32'd3000);
		rd(8'h00, 32'd500);
		foreach (pre[k]) if (pre[k] > 3000) pre[k] = 3000;
		wb(1'b1, `DFR_O_UPPCT, 32'd1000);
		wb(1'b1, `DFR_O_LOPCT, 32'd200);
		tgt(8'd0, 1'b1, 1200);
		wb(1'b1, `DFR_O_LOPCT, 32'd0);
		tgt(8'd9, 1'b1, pre[9]);
		$display("test limits done");
		wb(1'b1, `DFR_O_SKIP1, 32'd1000);
		wb(1'b1, `DFR_O_SKIP2, 32'd2000);
		tgt(8'd2, 1'b1, 1050);
		tgt(8'd5, 1'b1, 2050);
		wb(1'b1, `DFR_O_SKIP1, 32'd0);
		tgt(8'd2, 1'b1, 1000);
		$display("test skip done");
		tgt(8'd5, 1'b0, 0);
		// Output steps once a cycle; give it time to fall back to zero
		repeat (400) @(posedge clk);
		rd(`DFR_O_STATUS, 32'h0000_0000);
		wb(1'b1, `DFR_O_IFS, 32'h000C_A000);
		repeat (8) @(posedge clk);
		rd(`DFR_O_STATUS, 32'h0001_0000);
		$display("test alarm done");
		// Slow ramp periods so each press moves the value exactly once
		wb(1'b1, `DFR_O_ACCEL, 32'd1000);
		wb(1'b1, `DFR_O_DECEL, 32'd1000);
		wb(1'b1, `DFR_O_IFS, 32'h0000_00BA);
		tgt(8'h00, 1'b0, 0);
		tgt(8'h01, 1'b1, 1);
		tgt(8'h00, 1'b1, 1);
		rd(`DFR_O_REF, 32'h0000_0001);
		tgt(8'h01, 1'b0, 0);
		rd(`DFR_O_REF, 32'h0000_0000);
		tgt(8'h00, 1'b0, 0);
		wb(1'b1, `DFR_O_MODE, 32'd2);
		tgt(8'h01, 1'b0, 0);
		tgt(8'h00, 1'b1, 1);
		tgt(8'h00, 1'b0, 0);
		rd(`DFR_O_SAVED, 32'h0000_0001);
		wb(1'b1, `DFR_O_MODE, 32'd1);
		tgt(8'h02, 1'b0, 0);
		rd(`DFR_O_SAVED, 32'h0000_0000);
		wb(1'b1, `DFR_O_SAVED, 32'd700);
		tgt(8'h00, 1'b1, 700);
		tgt(8'h00, 1'b0, 0);
		rd(`DFR_O_SAVED, 32'd700);
		wb(1'b1, `DFR_O_MODE, 32'd2);
		wb(1'b1, `DFR_O_IFS, 32'h0000_DC00);
		wb(1'b1, `DFR_O_STEP, 32'd250);
		tgt(8'h04, 1'b1, 500);
		tgt(8'h00, 1'b1, 750);
		pins.set_pins(8'h08, 1'b1);
		repeat (60) @(posedge clk);
		tgt(8'h00, 1'b1, 749);
		rd(`DFR_O_REF, 32'h00F9_02ED);
		wb(1'b1, `DFR_O_STEP, 32'd0);
		tgt(8'h04, 1'b1, 750);
		tgt(8'h00, 1'b1, 750);
		wb(1'b1, `DFR_O_MODE, 32'd0);
		wb(1'b1, `DFR_O_IFS, 32'd0);
		tgt(8'h00, 1'b0, 0);
		wb(1'b1, `DFR_O_IFS, 32'h0000_DC00);
		rd(`DFR_O_REF, 32'h00FA_02EE);
		pins.set_pwr(1'b1);
		repeat (8) @(posedge clk);
		rd(`DFR_O_REF, 32'h0000_01F4);
		pins.set_pwr(1'b0);
		$display("test updown done");
		print_verdict();
	end
endmodule
